// ===== hw/two_edge_pkg.sv
package two_edge_pkg;

    // ==========================================================
    // address modifiers and field positions
    localparam logic [5:0] AM_6U = 6'h20;
    localparam logic [5:0] AM_3U = 6'h21;
    localparam int A2_COUNT_LSB = 8;
    localparam int A2_SLOT_LSB = 16;
    localparam int A2_SUB_LSB = 24;

    // ==========================================================
    // beat count codes
    localparam logic [7:0] BC_NONE = 8'h00;
    localparam logic [7:0] BC_MAX = 8'h80;
    localparam logic [7:0] BC_UNKNOWN = 8'hff;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS = 35;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SETUP_LAST = 4'(SETUP_CYC - 1);

    // ==========================================================
    // idle levels of the bus after reset
    localparam logic [2:0] RESP_IDLE = 3'h7;

    // ==========================================================
    // transfer outcome
    typedef enum logic [2:0] {
        RES_OK = 3'h0,
        RES_SUSPEND = 3'h1,
        RES_TERM = 3'h2,
        RES_ERROR = 3'h3,
        RES_REFUSED = 3'h4
    } result_t;

endpackage

// ===== hw/resp_if.sv
interface resp_if;
    logic dtack_n;
    logic berr_n;
    logic retry_n;
    logic [31:0] a;
    logic [31:0] d;
    modport src(output dtack_n, output berr_n, output retry_n, output a, output d);
    modport dst(input dtack_n, input berr_n, input retry_n, input a, input d);
endinterface

// ===== hw/pin_sync.sv
module pin_sync
    import two_edge_pkg::*;
#(
    parameter int W = 67
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic dtack_n_i,
    input wire logic berr_n_i,
    input wire logic retry_n_i,
    input wire logic [31:0] a_i,
    input wire logic [31:0] d_i,
    resp_if.src rs
);

    if (W != 67)
    begin : g_width_check
        $error("pin_sync width must be 67");
    end

    // ==========================================================
    // two stages; the first stage feeds nothing but the second
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t q;
    sync_t d;

    always_comb
    begin
        d = q;
        d.s1 = {dtack_n_i, berr_n_i, retry_n_i, a_i, d_i};
        d.s2 = q.s1;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            q <= {{RESP_IDLE, 64'h0}, {RESP_IDLE, 64'h0}};
        else
            q <= d;
    end

    assign rs.dtack_n = q.s2[66];
    assign rs.berr_n = q.s2[65];
    assign rs.retry_n = q.s2[64];
    assign rs.a = q.s2[63:32];
    assign rs.d = q.s2[31:0];

endmodule

// ===== hw/two_edge_master.sv
// How it works
// - dtack toggle without retry completes beat
// - retry before dtack toggle means suspend; phase one here ignores retry on the toggle
// - retry before berr means slave terminated
// - berr alone means slave error
// - any berr except a bus berr in phase two returns machine cleanly idle
// - strobe-only bus timers need long timeout
// - 6u phase one layout, modifier 0x20
// - 6u phase two fields, phase three reserved
// - 6u beats carry 64 bits
// - 3u phase one layout, modifier 0x21
// - 3u phase two and data layout
// - beat code is half beats, 0xff unknown
// - phase two ignores bus retry and bus berr; only the timer berr ends it
module two_edge_master
    import two_edge_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start_valid,
    output logic start_ready,
    input wire logic start_write,
    input wire logic start_3u,
    input wire logic [63:0] start_addr,
    input wire logic [7:0] start_xam,
    input wire logic [7:0] start_count,
    input wire logic [4:0] slot_number,
    input wire logic [7:0] subunit,
    input wire logic stop_req,
    input wire logic [15:0] bto_limit,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [63:0] wr_data,
    output logic rd_valid,
    output logic [63:0] rd_data,
    output logic done,
    output logic [2:0] result,
    output logic [8:0] beats_done,
    output logic [5:0] am_o,
    output logic as_n_o,
    output logic ds0_n_o,
    output logic ds1_n_o,
    output logic write_n_o,
    output logic bto_berr_n_o,
    output logic ctl_oe_n,
    output logic [31:0] a_o,
    output logic a_oe_n,
    input wire logic [31:0] a_i,
    output logic [31:0] d_o,
    output logic d_oe_n,
    input wire logic [31:0] d_i,
    input wire logic dtack_n_i,
    input wire logic berr_n_i,
    input wire logic retry_n_i
);

    // ==========================================================
    // state
    typedef enum logic [10:0] {
        S_IDLE = 11'b00000000001,
        S_A1SET = 11'b00000000010,
        S_A1WAIT = 11'b00000000100,
        S_A2SET = 11'b00000001000,
        S_A2WAIT = 11'b00000010000,
        S_A3SET = 11'b00000100000,
        S_A3WAIT = 11'b00001000000,
        S_LOAD = 11'b00010000000,
        S_BSET = 11'b00100000000,
        S_BWAIT = 11'b01000000000,
        S_END = 11'b10000000000
    } state_t;

    typedef struct packed {
        state_t st;
        logic [3:0] cnt;
        logic own;
        logic drv;
        logic as_n;
        logic ds0_n;
        logic ds1_n;
        logic wr;
        logic is3u;
        logic [63:0] addr;
        logic [7:0] extended_modifier_code;
        logic [7:0] code;
        logic [4:0] slot;
        logic [7:0] sub;
        logic [31:0] a;
        logic [31:0] d;
        logic dtack_prev;
        logic retry_seen;
        logic [8:0] beats;
        logic done;
        result_t res;
        logic rd_valid;
        logic [63:0] rd_data;
        logic [15:0] bto_cnt;
        logic bto_berr;
    } ctl_t;

    ctl_t q;
    ctl_t n;

    resp_if rs();

    pin_sync #(.W(67)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .dtack_n_i(dtack_n_i),
        .berr_n_i(berr_n_i),
        .retry_n_i(retry_n_i),
        .a_i(a_i),
        .d_i(d_i),
        .rs(rs)
    );

    // ==========================================================
    // response decode
    logic toggle;
    logic berr;
    logic retry_any;
    logic unknown;
    logic [8:0] total;
    logic bad_code;

    assign toggle = rs.dtack_n != q.dtack_prev;
    assign berr = !rs.berr_n || q.bto_berr;
    // a retry latched earlier in the beat still qualifies the response
    assign retry_any = !rs.retry_n || q.retry_seen;
    assign unknown = q.code == BC_UNKNOWN;
    assign total = {q.code, 1'b0};
    assign bad_code = start_count > BC_MAX && start_count != BC_UNKNOWN;

    assign start_ready = q.st == S_IDLE;
    assign wr_ready = q.st == S_LOAD && q.wr && !berr && !(stop_req && !q.beats[0]);

    // ==========================================================
    // next state
    always_comb
    begin
        n = q;
        n.done = 1'b0;
        n.rd_valid = 1'b0;
        n.dtack_prev = rs.dtack_n;
        if (!rs.retry_n)
            n.retry_seen = 1'b1;
        case (q.st)
            S_IDLE:
            begin
                n.retry_seen = 1'b0;
                if (start_valid && bad_code)
                begin
                    n.done = 1'b1;
                    n.res = RES_REFUSED;
                end
                else if (start_valid)
                begin
                    n.wr = start_write;
                    n.is3u = start_3u;
                    n.addr = start_addr;
                    n.extended_modifier_code = start_xam;
                    n.code = start_count;
                    n.slot = slot_number;
                    n.sub = subunit;
                    n.beats = 9'h000;
                    n.own = 1'b1;
                    n.drv = 1'b1;
                    n.cnt = 4'h0;
                    if (start_3u)
                    begin
                        n.a = {8'h00, start_addr[23:8], start_xam};
                        n.d = {16'h0000, start_addr[39:24]};
                    end
                    else
                    begin
                        n.a = {start_addr[31:8], start_xam};
                        n.d = start_addr[63:32];
                    end
                    n.st = S_A1SET;
                end
            end
            S_A1SET:
            begin
                n.cnt = q.cnt + 4'h1;
                if (q.cnt == SETUP_LAST)
                begin
                    n.as_n = 1'b0;
                    n.ds0_n = 1'b0;
                    n.retry_seen = 1'b0;
                    n.st = S_A1WAIT;
                end
            end
            S_A1WAIT:
            begin
                if (berr)
                begin
                    n.res = retry_any ? RES_TERM : RES_ERROR;
                    n.st = S_END;
                end
                else if (toggle)
                begin
                    n.cnt = 4'h0;
                    n.a = {8'h00, 3'b000, q.slot, q.code, q.addr[7:0]};
                    if (q.is3u)
                        n.d = {24'h000000, q.sub};
                    else
                    begin
                        n.a[31:A2_SUB_LSB] = q.sub;
                        n.d = 32'h00000000;
                    end
                    n.st = S_A2SET;
                end
            end
            S_A2SET:
            begin
                n.cnt = q.cnt + 4'h1;
                if (q.cnt == SETUP_LAST)
                begin
                    n.ds1_n = 1'b0;
                    n.st = S_A2WAIT;
                end
            end
            S_A2WAIT:
            begin
                // bus retry and berr mean nothing here, but our own timer
                // must still free a phase that the slave never answers
                if (q.bto_berr)
                begin
                    n.res = RES_ERROR;
                    n.st = S_END;
                end
                else if (toggle)
                begin
                    n.cnt = 4'h0;
                    n.a = 32'h00000000;
                    n.d = 32'h00000000;
                    n.st = S_A3SET;
                end
            end
            S_A3SET:
            begin
                n.cnt = q.cnt + 4'h1;
                if (q.cnt == SETUP_LAST)
                begin
                    n.ds1_n = 1'b1;
                    n.retry_seen = 1'b0;
                    n.st = S_A3WAIT;
                end
            end
            S_A3WAIT:
            begin
                if (berr)
                begin
                    n.res = retry_any ? RES_TERM : RES_ERROR;
                    n.st = S_END;
                end
                else if (toggle && retry_any)
                begin
                    n.res = RES_SUSPEND;
                    n.st = S_END;
                end
                else if (toggle && q.code == BC_NONE)
                begin
                    n.res = RES_OK;
                    n.st = S_END;
                end
                else if (toggle)
                begin
                    n.drv = q.wr;
                    n.st = S_LOAD;
                end
            end
            S_LOAD:
            begin
                if (berr)
                begin
                    n.res = RES_ERROR;
                    n.st = S_END;
                end
                else if (stop_req && !q.beats[0])
                begin
                    n.res = RES_OK;
                    n.st = S_END;
                end
                else if (!q.wr || wr_valid)
                begin
                    n.cnt = 4'h0;
                    if (q.is3u)
                    begin
                        n.a = {16'h0000, wr_data[31:16]};
                        n.d = {16'h0000, wr_data[15:0]};
                    end
                    else
                    begin
                        n.a = wr_data[63:32];
                        n.d = wr_data[31:0];
                    end
                    n.st = S_BSET;
                end
            end
            S_BSET:
            begin
                n.cnt = q.cnt + 4'h1;
                if (berr)
                begin
                    n.res = RES_ERROR;
                    n.st = S_END;
                end
                else if (q.cnt == SETUP_LAST)
                begin
                    n.ds1_n = !q.ds1_n;
                    n.retry_seen = 1'b0;
                    n.st = S_BWAIT;
                end
            end
            S_BWAIT:
            begin
                if (berr)
                begin
                    n.res = retry_any ? RES_TERM : RES_ERROR;
                    n.st = S_END;
                end
                else if (toggle && retry_any)
                begin
                    n.res = RES_SUSPEND;
                    n.st = S_END;
                end
                else if (toggle)
                begin
                    n.beats = q.beats + 9'h001;
                    if (!q.wr)
                    begin
                        n.rd_valid = 1'b1;
                        if (q.is3u)
                            n.rd_data = {32'h00000000, rs.a[15:0], rs.d[15:0]};
                        else
                            n.rd_data = {rs.a, rs.d};
                    end
                    if (!unknown && q.beats + 9'h001 == total)
                    begin
                        n.res = RES_OK;
                        n.st = S_END;
                    end
                    else
                        n.st = S_LOAD;
                end
            end
            S_END:
            begin
                // let go of the bus and wait for the slave to release dtack and
                // berr, so a late dtack never lands in the next transfer
                n.as_n = 1'b1;
                n.ds0_n = 1'b1;
                n.ds1_n = 1'b1;
                n.drv = 1'b0;
                if (rs.dtack_n && rs.berr_n)
                begin
                    n.own = 1'b0;
                    n.done = 1'b1;
                    n.st = S_IDLE;
                end
            end
            default:
            begin
                n.st = S_IDLE;
            end
        endcase
        // timeout timer: limit in clk cycles, chosen at integration
        if ((q.ds0_n && q.ds1_n) || toggle || n.ds0_n != q.ds0_n || n.ds1_n != q.ds1_n)
        begin
            n.bto_cnt = 16'h0000;
            n.bto_berr = 1'b0;
        end
        else if (q.bto_cnt >= bto_limit)
            n.bto_berr = 1'b1;
        else
            n.bto_cnt = q.bto_cnt + 16'h0001;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            q <= '0;
            q.st <= S_IDLE;
            q.as_n <= 1'b1;
            q.ds0_n <= 1'b1;
            q.ds1_n <= 1'b1;
            q.dtack_prev <= 1'b1;
            q.res <= RES_OK;
        end
        else
            q <= n;
    end

    // ==========================================================
    // pins
    assign am_o = q.is3u ? AM_3U : AM_6U;
    assign as_n_o = q.as_n;
    assign ds0_n_o = q.ds0_n;
    assign ds1_n_o = q.ds1_n;
    assign write_n_o = !q.wr;
    assign ctl_oe_n = !q.own;
    assign a_o = q.a;
    assign d_o = q.d;
    assign a_oe_n = !q.drv;
    assign d_oe_n = !q.drv;
    assign rd_valid = q.rd_valid;
    assign rd_data = q.rd_data;
    assign done = q.done;
    assign result = q.res;
    assign beats_done = q.beats;
    assign bto_berr_n_o = !q.bto_berr;

endmodule

// ===== sim/two_edge_props.sv
module two_edge_props
    import two_edge_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start_valid,
    input wire logic start_ready,
    input wire logic start_3u,
    input wire logic [63:0] start_addr,
    input wire logic [7:0] start_xam,
    input wire logic [7:0] start_count,
    input wire logic done,
    input wire logic [2:0] result,
    input wire logic [5:0] am_o,
    input wire logic as_n_o,
    input wire logic ds1_n_o,
    input wire logic [31:0] a_o,
    input wire logic a_oe_n,
    input wire logic [31:0] d_o,
    input wire logic d_oe_n,
    input wire logic berr_n_i,
    input wire logic ctl_oe_n,
    input wire logic bto_berr_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic u3_q;
    logic take;
    logic bad_code;
    assign take = start_valid && start_ready;
    assign bad_code = start_count inside {[8'h81:8'hfe]};
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            u3_q <= 1'b0;
        else if (take)
            u3_q <= start_3u;
    end
    // ==========
    // assertions
    am_code_a: assert property (!as_n_o |-> !ctl_oe_n &&
        am_o == (u3_q ? AM_3U : AM_6U))
        else $error("address modifier wrong");
    layout6_a: assert property (take && !start_3u && !bad_code |=> !a_oe_n &&
        a_o == {start_addr[31:8], start_xam} && d_o == start_addr[63:32])
        else $error("6u first phase layout wrong");
    layout3_a: assert property (take && start_3u && !bad_code |=> !a_oe_n &&
        a_o == {8'h0, start_addr[23:8], start_xam} && d_o == {16'h0, start_addr[39:24]})
        else $error("3u first phase layout wrong");
    as_setup_a: assert property ($fell(as_n_o) |-> !$past(a_oe_n, 4) && $stable(a_o))
        else $error("address strobe without setup");
    strobe_setup_a: assert property ($changed(ds1_n_o) && !as_n_o |-> $stable(a_o) && $stable(d_o))
        else $error("data strobe moved with the lines");
    refused_a: assert property (take && bad_code |-> ##[1:2] (done && result == RES_REFUSED))
        else $error("reserved beat code not refused");
    done_idle_a: assert property (done |-> as_n_o && ds1_n_o && a_oe_n && d_oe_n ##1 start_ready)
        else $error("transfer ended unclean");
    berr_end_a: assert property (!berr_n_i && !as_n_o |-> ##[1:20] as_n_o)
        else $error("bus error did not end transfer");
    timer_end_a: assert property (!bto_berr_n_o |-> !as_n_o ##[1:3] as_n_o)
        else $error("timeout did not end transfer");
    cover property (done && result == RES_SUSPEND);
    cover property (done && result == RES_TERM);
    cover property (done && result == RES_OK && u3_q);
    cover property (!bto_berr_n_o);
endmodule

bind two_edge_master two_edge_props u_props (.clk(clk), .sys_rst(sys_rst),
    .start_valid(start_valid), .start_ready(start_ready), .start_3u(start_3u),
    .start_addr(start_addr), .start_xam(start_xam), .start_count(start_count), .done(done),
    .result(result), .am_o(am_o), .as_n_o(as_n_o), .ds1_n_o(ds1_n_o), .a_o(a_o),
    .a_oe_n(a_oe_n), .d_o(d_o), .d_oe_n(d_oe_n), .berr_n_i(berr_n_i),
    .ctl_oe_n(ctl_oe_n), .bto_berr_n_o(bto_berr_n_o));

// ===== sim/two_edge_slave.sv
module two_edge_slave
    import two_edge_pkg::*;
(
    input wire logic clk,
    input wire logic [5:0] am,
    input wire logic as_n,
    input wire logic ds0_n,
    input wire logic ds1_n,
    input wire logic write_n,
    input wire logic [31:0] a,
    input wire logic [31:0] d,
    input wire logic [1:0] mode,
    input wire logic [3:0] fault_ev,
    output logic dtack_n,
    output logic berr_n,
    output logic retry_n,
    output logic [31:0] a_s,
    output logic [31:0] d_s
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cap_a [16];
    logic [31:0] cap_d [16];
    logic [63:0] p;
    logic last_ds;
    logic drv;
    int ev;
    // ==========
    // one event per strobe edge, answered after a lag of one or two cycles, one cycle more for read data beats
    initial
    begin
        {dtack_n, berr_n, retry_n} = 3'h7;
        a_s = 32'h0;
        d_s = 32'h0;
        drv = 1'b0;
        ev = 0;
        last_ds = 1'b1;
        forever
        begin
            @(posedge clk);
            #1;
            if (!drv)
            begin
                // released lines keep moving so stale data never matches
                a_s = ~a_s;
                d_s = ~d_s;
            end
            if (as_n)
            begin
                {dtack_n, berr_n, retry_n} = 3'h7;
                drv = 1'b0;
                ev = 0;
                last_ds = 1'b1;
            end
            else if (!ds0_n && (ev == 0 || ds1_n != last_ds))
            begin
                last_ds = ds1_n;
                cap_a[ev] = a;
                cap_d[ev] = d;
                if (mode == 2'h0 && fault_ev == 4'hf && ev == 1)
                    wait (as_n);
                repeat (ev % 2 + 1) @(posedge clk);
                #1;
                if (ev == fault_ev && mode != 2'h0)
                begin
                    if (mode != 2'h3)
                    begin
                        retry_n = 1'b0;
                        repeat (2) @(posedge clk);
                        #1;
                    end
                    if (mode == 2'h1)
                    begin
                        dtack_n = ~dtack_n;
                        retry_n = 1'b1;
                    end
                    else
                        berr_n = 1'b0;
                end
                else
                begin
                    if (ev > 2 && write_n)
                    begin
                        p = {8'(ev), 24'h5a5a5a, 8'(ev), 24'hc3c3c3};
                        drv = 1'b1;
                        a_s = (am == AM_3U) ? {16'h0, p[31:16]} : p[63:32];
                        d_s = (am == AM_3U) ? {16'h0, p[15:0]} : p[31:0];
                        @(posedge clk);
                        #1;
                    end
                    dtack_n = ~dtack_n;
                end
                ev++;
            end
        end
    end
endmodule

// ===== sim/two_edge_block_transfer_phases_tb.sv
module two_edge_block_transfer_phases_tb
    import two_edge_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, start_valid, start_write, start_3u, stop_req, wr_valid;
    logic start_ready, wr_ready, rd_valid, done, as_n_o, ds0_n_o, ds1_n_o, write_n_o;
    logic a_oe_n, d_oe_n, dtack_n, berr_n, retry_n, bto_berr_n;
    logic [15:0] bto_limit;
    logic [63:0] start_addr, wr_data, rd_data;
    logic [7:0] start_count, subunit, start_xam, wr_idx;
    logic [4:0] slot_number;
    logic [2:0] result;
    logic [8:0] beats_done;
    logic [5:0] am_o;
    logic [31:0] a_o, d_o, a_s, d_s, a_bus, d_bus;
    logic [1:0] mode;
    logic [3:0] fault_ev;
    logic [63:0] rd_q [$];
    int bad_count = 0;
    int samples_checked = 0;
    assign a_bus = a_oe_n ? a_s : a_o;
    assign d_bus = d_oe_n ? d_s : d_o;
    two_edge_master u_dut (.clk(clk), .sys_rst(sys_rst), .start_valid(start_valid),
        .start_ready(start_ready), .start_write(start_write), .start_3u(start_3u),
        .start_addr(start_addr), .start_xam(start_xam), .start_count(start_count),
        .slot_number(slot_number), .subunit(subunit), .stop_req(stop_req), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
        .done(done), .result(result), .beats_done(beats_done), .am_o(am_o), .as_n_o(as_n_o),
        .ds0_n_o(ds0_n_o), .ds1_n_o(ds1_n_o), .write_n_o(write_n_o), .ctl_oe_n(), .a_o(a_o),
        .a_oe_n(a_oe_n), .a_i(a_bus), .d_o(d_o), .d_oe_n(d_oe_n), .d_i(d_bus),
        .dtack_n_i(dtack_n), .berr_n_i(berr_n), .retry_n_i(retry_n), .bto_limit(bto_limit),
        .bto_berr_n_o(bto_berr_n));
    two_edge_slave u_slave (.clk(clk), .am(am_o), .as_n(as_n_o), .ds0_n(ds0_n_o),
        .ds1_n(ds1_n_o), .write_n(write_n_o), .a(a_bus), .d(d_bus), .mode(mode),
        .fault_ev(fault_ev), .dtack_n(dtack_n), .berr_n(berr_n), .retry_n(retry_n),
        .a_s(a_s), .d_s(d_s));
    // ==========
    // helpers
    function automatic logic [63:0] wpat(input logic [7:0] i);
        return {i, 24'h111111, i, 24'h222222};
    endfunction
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic run(input logic w, input logic u3, input logic [63:0] ad, input logic [7:0] c);
        int n;
        n = 0;
        rd_q.delete();
        @(posedge clk);
        start_write <= w;
        start_3u <= u3;
        start_addr <= ad;
        start_count <= c;
        start_valid <= 1'b1;
        wr_idx <= 8'h0;
        wr_data <= wpat(8'h0);
        @(posedge clk);
        start_valid <= 1'b0;
        while (done !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000)
            bad_count++;
    endtask
    always @(posedge clk)
    begin
        if (wr_valid && wr_ready)
        begin
            wr_idx <= wr_idx + 8'h1;
            wr_data <= wpat(wr_idx + 8'h1);
        end
        if (rd_valid === 1'b1)
            rd_q.push_back(rd_data);
    end
    // ==========
    // scenarios
    task automatic s_write6();
        logic [63:0] ad;
        ad = 64'h0000_0012_3456_7800;
        run(1'b1, 1'b0, ad, 8'h01);
        check("ph1", {u_slave.cap_a[0], u_slave.cap_d[0]}, {ad[31:8], start_xam, ad[63:32]});
        check("ph2", {u_slave.cap_a[1], u_slave.cap_d[1]},
            {subunit, 3'h0, slot_number, 8'h01, ad[7:0], 32'h0});
        check("ph3", {u_slave.cap_a[2], u_slave.cap_d[2]}, 64'h0);
        for (int k = 0; k < 2; k++)
            check("wbeat", {u_slave.cap_a[3 + k], u_slave.cap_d[3 + k]}, wpat(8'(k)));
        check("beats", 64'(beats_done), 64'h2);
    endtask
    task automatic s_read3();
        logic [63:0] ad;
        ad = 64'h0000_0045_6789_ab10;
        run(1'b0, 1'b1, ad, 8'h01);
        check("ph1", {u_slave.cap_a[0], u_slave.cap_d[0]},
            {8'h0, ad[23:8], start_xam, 16'h0, ad[39:24]});
        check("ph2", {u_slave.cap_a[1], u_slave.cap_d[1]},
            {8'h0, 3'h0, slot_number, 8'h01, ad[7:0], 24'h0, subunit});
        check("reads", 64'(rd_q.size()), 64'h2);
        for (int k = 0; k < 2; k++)
            check("rbeat", rd_q[k], {32'h0, 8'(k + 3), 24'hc3c3c3});
    endtask
    // rows: mode, faulted event, beat code, result, beats
    task automatic s_table();
        logic [23:0] rows [10];
        rows = '{24'h130110, 24'h240121, 24'h330130, 24'h110102, 24'h300130,
            24'h000000, 24'h008140, 24'h00fe40, 24'h25ff22, 24'h000102};
        for (int r = 0; r < 10; r++)
        begin
            @(posedge clk);
            mode <= rows[r][21:20];
            fault_ev <= rows[r][19:16];
            run(1'b1, 1'b0, 64'h0000_0000_0000_4000, rows[r][15:8]);
            check("result", 64'(result), 64'(rows[r][7:4]));
            if (rows[r][7:4] != 4'h4)
                check("beats", 64'(beats_done), 64'(rows[r][3:0]));
            @(negedge clk);
            check("ready", 64'(start_ready), 64'h1);
        end
    endtask
    task automatic s_stop();
        fork
            run(1'b1, 1'b0, 64'h0000_0000_0000_8000, BC_UNKNOWN);
            begin
                wait (beats_done == 9'h001);
                @(posedge clk);
                stop_req <= 1'b1;
            end
        join
        stop_req <= 1'b0;
        check("stop result", 64'(result), 64'(RES_OK));
        check("stop beats", 64'(beats_done), 64'h2);
    endtask
    // slave stays silent in phase two; only the timer can end it
    task automatic s_timeout();
        @(posedge clk);
        mode <= 2'h0;
        fault_ev <= 4'hf;
        run(1'b1, 1'b0, 64'h0000_0000_0000_6000, 8'h01);
        check("timer result", 64'(result), 64'(RES_ERROR));
        check("timer beats", 64'(beats_done), 64'h0);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // twenty times the 3000-cycle limit of one run
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        sys_rst = 1'b1;
        {start_valid, start_write, start_3u, stop_req} = 4'h0;
        wr_valid = 1'b1;
        start_addr = 64'h0;
        wr_data = 64'h0;
        wr_idx = 8'h0;
        start_count = 8'h0;
        start_xam = 8'h11;
        subunit = 8'h3c;
        slot_number = 5'h0b;
        mode = 2'h0;
        fault_ev = 4'h0;
        bto_limit = 16'h0032;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        s_write6();
        s_read3();
        s_table();
        s_stop();
        s_timeout();
        report_and_stop();
    end
endmodule
